// ### rtl/vip_vector_issue_pipeline.sv
// Behaviour
// RULE1 - four independent pipelined vector units
// RULE2 - at most two issues per cycle
// RULE3 - only two lowest queue slots issue
// RULE4 - second slot may bypass waiting lowest
// RULE5 - permute unit is two stages deep
// RULE6 - long integer and float units four-stage
// RULE7 - at most ten instructions executing together
// RULE8 - short integer result one cycle after issue
// RULE9 - each unit accepts one instruction per cycle
// RULE10 - dispatch places at most two per cycle
// RULE11 - sixteen rename buffers track vector results
// RULE12 - issue needs ready operands and accepting unit
`default_nettype none
module vip_vector_issue_pipeline (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Dispatch side
    input wire logic [vip_pkg::DISPATCH_WIDTH-1:0] disp_valid,
    input wire vip_pkg::vip_instr_t [vip_pkg::DISPATCH_WIDTH-1:0] disp_instr,
    output logic disp_ready_q,
    // Results, one per unit
    output logic [vip_pkg::UNITS-1:0] res_valid,
    output var vip_pkg::vip_rename_t [vip_pkg::UNITS-1:0] res_dest,
    // Status
    output logic [1:0] issued_count_q,
    output logic [3:0] queue_count_q,
    output logic [3:0] in_flight_q
);
    vip_pkg::vip_instr_t queue_q [vip_pkg::QUEUE_DEPTH];
    logic [vip_pkg::QUEUE_DEPTH-1:0] qvalid_q;
    vip_pkg::vip_instr_t queue_d [vip_pkg::QUEUE_DEPTH];
    logic [vip_pkg::QUEUE_DEPTH-1:0] qvalid_d;
    vip_pkg::vip_stage_t pipe_q [vip_pkg::UNITS][vip_pkg::MAX_STAGES];
    logic [vip_pkg::RENAME_BUFS-1:0] rename_ready_q;
    logic issue0;
    logic issue1;
    logic can0;
    logic can1;
    logic [3:0] occ_base;
    logic [3:0] count_d;
    logic [3:0] occ_d;

    function automatic int unit_depth(input vip_pkg::vip_unit_t u);
        case (u)
            vip_pkg::UNIT_PERMUTE: unit_depth = vip_pkg::DEPTH_PERMUTE;
            vip_pkg::UNIT_INT_SHORT: unit_depth = vip_pkg::DEPTH_INT_SHORT;
            vip_pkg::UNIT_INT_LONG: unit_depth = vip_pkg::DEPTH_INT_LONG;
            default: unit_depth = vip_pkg::DEPTH_FLOAT;
        endcase
    endfunction

    // Sources are ready when not needed or their rename buffer holds data.
    function automatic logic operands_ready(input vip_pkg::vip_instr_t ins,
        input logic [vip_pkg::RENAME_BUFS-1:0] rdy);
        operands_ready = (!ins.src_need[0] || rdy[ins.src[0]]) &&
            (!ins.src_need[1] || rdy[ins.src[1]]);
    endfunction

    // Last stage of every unit drives the result straight from its flop.
    always_comb
    begin
        for (int u = 0; u < vip_pkg::UNITS; u++)
        begin
            res_valid[u] = pipe_q[u][unit_depth(2'(u)) - 1].valid;
            res_dest[u] = pipe_q[u][unit_depth(2'(u)) - 1].dest;
        end
    end

    // Occupancy left after the last stages retire this cycle.
    always_comb
    begin
        occ_base = 4'h0;
        for (int u = 0; u < vip_pkg::UNITS; u++)
        begin
            for (int s = 0; s < vip_pkg::MAX_STAGES - 1; s++)
            begin
                if (s < unit_depth(2'(u)) - 1 && pipe_q[u][s].valid)
                begin
                    occ_base = occ_base + 4'h1;
                end
            end
        end
    end

    // Issue choice over the two lowest slots only.
    always_comb
    begin
        can0 = qvalid_q[0]
            && operands_ready(queue_q[0], rename_ready_q); // [RULE3][RULE12]
        can1 = qvalid_q[1] // [RULE9]
            && operands_ready(queue_q[1], rename_ready_q) // [RULE12]
            && !(can0 && queue_q[1].unit == queue_q[0].unit); // [RULE4]
        issue0 = 1'b0;
        issue1 = 1'b0;
        if (occ_base + 4'h2 <= 4'(vip_pkg::MAX_IN_FLIGHT))
        begin
            issue0 = can0; // [RULE2] [RULE7]
            issue1 = can1;
        end
        else if (occ_base + 4'h1 <= 4'(vip_pkg::MAX_IN_FLIGHT))
        begin
            issue0 = can0; // [RULE7]
            issue1 = can1 && !can0;
        end
    end

    assign occ_d = occ_base + 4'(issue0) + 4'(issue1);

    // Queue compaction after issue, then append of dispatched entries.
    always_comb
    begin
        int n;
        n = 0;
        for (int i = 0; i < vip_pkg::QUEUE_DEPTH; i++)
        begin
            queue_d[i] = queue_q[i];
            qvalid_d[i] = 1'b0;
        end
        for (int i = 0; i < vip_pkg::QUEUE_DEPTH; i++)
        begin
            if (qvalid_q[i] && !(i == 0 && issue0) && !(i == 1 && issue1))
            begin
                queue_d[n] = queue_q[i];
                qvalid_d[n] = 1'b1;
                n = n + 1;
            end
        end
        for (int k = 0; k < vip_pkg::DISPATCH_WIDTH; k++)
        begin
            if (disp_valid[k] && n < vip_pkg::QUEUE_DEPTH) // [RULE10]
            begin
                queue_d[n] = disp_instr[k];
                qvalid_d[n] = 1'b1;
                n = n + 1;
            end
        end
        count_d = 4'(n);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            qvalid_q <= '0;
            queue_count_q <= 4'h0;
            disp_ready_q <= 1'b0;
        end
        else
        begin
            qvalid_q <= qvalid_d;
            queue_count_q <= count_d;
            disp_ready_q <= count_d + 4'(vip_pkg::DISPATCH_WIDTH)
                <= 4'(vip_pkg::QUEUE_DEPTH); // [RULE10]
        end
    end

    always_ff @(posedge clk)
    begin
        for (int i = 0; i < vip_pkg::QUEUE_DEPTH; i++)
        begin
            queue_q[i] <= queue_d[i];
        end
    end

    // Unit pipelines advance every cycle and never stall.
    always_ff @(posedge clk)
    begin
        for (int u = 0; u < vip_pkg::UNITS; u++)
        begin
            for (int s = vip_pkg::MAX_STAGES - 1; s > 0; s--)
            begin
                if (rst || s >= unit_depth(2'(u)))
                begin
                    pipe_q[u][s] <= '0;
                end
                else
                begin
                    pipe_q[u][s] <= pipe_q[u][s-1]; // [RULE1] [RULE5] [RULE6]
                end
            end
            if (rst)
            begin
                pipe_q[u][0] <= '0;
            end
            else if (issue0 && queue_q[0].unit == 2'(u))
            begin
                pipe_q[u][0] <= '{valid: 1'b1,
                    dest: queue_q[0].dest}; // [RULE8]
            end
            else if (issue1 && queue_q[1].unit == 2'(u))
            begin
                pipe_q[u][0] <= '{valid: 1'b1,
                    dest: queue_q[1].dest}; // [RULE9]
            end
            else
            begin
                pipe_q[u][0] <= '0;
            end
        end
    end

    // A result write wins over a new producer's clear of the same buffer.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rename_ready_q <= vip_pkg::RENAME_READY_RESET;
        end
        else
        begin
            for (int k = 0; k < vip_pkg::DISPATCH_WIDTH; k++)
            begin
                if (disp_valid[k])
                begin
                    rename_ready_q[disp_instr[k].dest] <= 1'b0; // [RULE11]
                end
            end
            for (int u = 0; u < vip_pkg::UNITS; u++)
            begin
                if (res_valid[u])
                begin
                    rename_ready_q[res_dest[u]] <= 1'b1; // [RULE11]
                end
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            issued_count_q <= 2'h0;
            in_flight_q <= 4'h0;
        end
        else
        begin
            issued_count_q <= 2'(issue0) + 2'(issue1); // [RULE2]
            in_flight_q <= occ_d; // [RULE7]
        end
    end
endmodule
`default_nettype wire

// ### rtl/vip_pkg.sv
`default_nettype none
package vip_pkg;
    localparam int UNITS = 4;
    localparam int MAX_STAGES = 4;
    localparam int QUEUE_DEPTH = 8;
    localparam int RENAME_BUFS = 16;
    localparam int MAX_IN_FLIGHT = 10;
    localparam int ISSUE_WIDTH = 2;
    localparam int DISPATCH_WIDTH = 2;

    localparam logic [1:0] UNIT_PERMUTE = 2'h0;
    localparam logic [1:0] UNIT_INT_SHORT = 2'h1;
    localparam logic [1:0] UNIT_INT_LONG = 2'h2;
    localparam logic [1:0] UNIT_FLOAT = 2'h3;

    localparam int DEPTH_PERMUTE = 2;
    localparam int DEPTH_INT_SHORT = 1;
    localparam int DEPTH_INT_LONG = 4;
    localparam int DEPTH_FLOAT = 4;

    localparam logic [RENAME_BUFS-1:0] RENAME_READY_RESET = 16'hffff;

    typedef logic [3:0] vip_rename_t;
    typedef logic [1:0] vip_unit_t;

    typedef struct packed {
        vip_unit_t unit;
        vip_rename_t dest;
        logic [1:0] src_need;
        vip_rename_t [1:0] src;
    } vip_instr_t;

    typedef struct packed {
        logic valid;
        vip_rename_t dest;
    } vip_stage_t;
endpackage
`default_nettype wire

// ### verification/vip_disp_model.sv
`default_nettype none
module vip_disp_model (
    // Clock and flow control
    input wire logic clk,
    input wire logic disp_ready_q,
    // Dispatch lanes
    output logic [1:0] disp_valid,
    output var vip_pkg::vip_instr_t [1:0] disp_instr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        disp_valid = 2'h0;
        disp_instr = '0;
    end
    task automatic send(input logic [1:0] v, input vip_pkg::vip_instr_t a,
                        input vip_pkg::vip_instr_t b);
        while (disp_ready_q !== 1'b1)
            @(negedge clk);
        disp_valid = v;
        disp_instr = {b, a};
        @(negedge clk);
    endtask
    // Idle lanes carry scrambled data so stale entries never look valid.
    task automatic idle;
        disp_valid = 2'h0;
        disp_instr = ~disp_instr;
    endtask
endmodule
`default_nettype wire

// ### verification/vip_vector_issue_pipeline_chk.sv
`default_nettype none
module vip_vector_issue_pipeline_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Observed outputs
    input wire logic [3:0] res_valid,
    input wire logic [1:0] issued_count_q,
    input wire logic [3:0] queue_count_q,
    input wire logic [3:0] in_flight_q
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    a_issue_two_max: assert property (issued_count_q <= 2'h2)
        else $error("more than two issued");
    a_flight_cap: assert property (in_flight_q <= 4'ha)
        else $error("too many in flight");
    a_issue_from_queue: assert property (
        issued_count_q <= $past(queue_count_q))
        else $error("issue beyond queue contents");
    a_short_one: assert property (
        res_valid[1] |-> issued_count_q != 2'h0)
        else $error("short result without issue");
    a_permute_two: assert property (
        res_valid[0] |-> $past(issued_count_q) != 2'h0)
        else $error("permute result timing");
    a_long_four: assert property (
        res_valid[2] |-> $past(issued_count_q, 3) != 2'h0)
        else $error("long result timing");
    a_float_four: assert property (
        res_valid[3] |-> $past(issued_count_q, 3) != 2'h0)
        else $error("float result timing");
    a_flight_growth: assert property (
        in_flight_q <= $past(in_flight_q) + 4'h2)
        else $error("in flight grew too fast");
    c_two_issued: cover property (issued_count_q == 2'h2);
    c_queue_busy: cover property (queue_count_q >= 4'h2);
    c_short_res: cover property (res_valid[1]);
endmodule
bind vip_vector_issue_pipeline vip_vector_issue_pipeline_chk chk (
    .clk(clk), .rst(rst), .res_valid(res_valid),
    .issued_count_q(issued_count_q), .queue_count_q(queue_count_q),
    .in_flight_q(in_flight_q));
`default_nettype wire

// ### verification/vip_vector_issue_pipeline_tb.sv
`default_nettype none
module vip_vector_issue_pipeline_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] dv;
    vip_pkg::vip_instr_t [1:0] di;
    logic rdy;
    logic [3:0] rv;
    vip_pkg::vip_rename_t [3:0] rd;
    logic [1:0] ic;
    logic [3:0] qc;
    logic [3:0] fc;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;
    int lat[4] = '{vip_pkg::DEPTH_PERMUTE, vip_pkg::DEPTH_INT_SHORT,
                   vip_pkg::DEPTH_INT_LONG, vip_pkg::DEPTH_FLOAT};
    always #12.5 clk = ~clk;
    vip_vector_issue_pipeline dut (.clk(clk), .rst(rst), .disp_valid(dv),
        .disp_instr(di), .disp_ready_q(rdy), .res_valid(rv), .res_dest(rd),
        .issued_count_q(ic), .queue_count_q(qc), .in_flight_q(fc));
    vip_disp_model disp (.clk(clk), .disp_ready_q(rdy), .disp_valid(dv),
        .disp_instr(di));
    function automatic vip_pkg::vip_instr_t mk(logic [1:0] u,
        logic [3:0] d, logic [1:0] n, logic [3:0] s);
        return {u, d, n, 4'h0, s};
    endfunction
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_res(int u, output int n);
        n = 0;
        while (rv[u] !== 1'b1 && n < 20)
        begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic t_latency;
        int n;
        for (int u = 0; u < 4; u++)
        begin
            disp.send(2'h1, mk(u[1:0], u[3:0], 2'h0, 4'h0), '0);
            check("queue count", {4'h0, qc}, 8'h1);
            disp.idle();
            wait_res(u, n);
            check("latency", n[7:0], lat[u][7:0]);
            check("dest", rd[u], u[7:0]);
        end
    endtask
    task automatic t_ooo;
        int n;
        disp.send(2'h1, mk(2'h2, 4'h2, 2'h0, 4'h0), '0);
        disp.send(2'h3, mk(2'h0, 4'h3, 2'h1, 4'h2), mk(2'h1, 4'h4, 2'h0, 4'h0));
        disp.idle();
        wait_res(1, n);
        check("bypass", n[7:0], 8'h1);
        @(negedge clk);
        check("early", {7'h0, rv[0]}, 8'h0);
        wait_res(2, n);
        check("producer", rd[2], 8'h2);
        @(negedge clk);
        check("early", {7'h0, rv[0]}, 8'h0);
        wait_res(0, n);
        check("wakeup", n[7:0], 8'h2);
        check("consumer", rd[0], 8'h3);
    endtask
    task automatic t_conflict;
        int n;
        disp.send(2'h3, mk(2'h1, 4'h5, 2'h0, 4'h0), mk(2'h1, 4'h6, 2'h0, 4'h0));
        disp.idle();
        wait_res(1, n);
        check("slot0 first", rd[1], 8'h5);
        @(negedge clk);
        check("slot1 next", {7'h0, rv[1]}, 8'h1);
        check("slot1 dest", rd[1], 8'h6);
    endtask
    task automatic t_stream;
        int nl;
        int nf;
        int pk;
        int pf;
        nl = 0;
        nf = 0;
        pk = 0;
        pf = 0;
        for (int k = 0; k < 4; k++)
            disp.send(2'h3, mk(2'h2, 4'h8 + k[3:0], 2'h0, 4'h0),
                      mk(2'h3, 4'hc + k[3:0], 2'h0, 4'h0));
        disp.idle();
        for (int c = 0; c < 12; c++)
        begin
            nl += int'(rv[2] === 1'b1);
            nf += int'(rv[3] === 1'b1);
            pk = (int'(ic) > pk) ? int'(ic) : pk;
            pf = (int'(fc) > pf) ? int'(fc) : pf;
            @(negedge clk);
        end
        check("long count", nl[7:0], 8'h4);
        check("float count", nf[7:0], 8'h4);
        check("peak issue", pk[7:0], 8'h2);
        check("peak flight", pf[7:0], 8'h8);
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            err_count++;
            complete_run();
        end
    end
    initial
    begin
        repeat (8) @(negedge clk);
        check("ready in reset", {7'h0, rdy}, 8'h0);
        check("result in reset", {4'h0, rv}, 8'h0);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        check("ready", {7'h0, rdy}, 8'h1);
        t_latency();
        t_ooo();
        t_conflict();
        t_stream();
        complete_run();
    end
endmodule
`default_nettype wire
